/* bench/sscr_nvm_model.sv */
// nvm engine stand-in answering load and program starts
`timescale 1ns/10ps
`default_nettype none
module sscr_nvm_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // engine side
    input wire logic load_start,
    input wire logic prog_start,
    input wire logic [7:0] delay,
    output logic nvm_done
);
    // ========================================
    // busy countdown, done pulse at its end
    int cnt;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 0;
            nvm_done <= 1'b0;
        end else begin
            nvm_done <= (cnt == 1);
            if (load_start || prog_start) begin
                cnt <= int'(delay);
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule
`default_nettype wire

/* bench/sscr_regs_tb.sv */
// self-checking bench for the register bank
`timescale 1ns/10ps
`default_nettype none
`include "sscr_consts.svh"
module sscr_regs_tb;
    import sscr_pkg::*;
    // ========================================
    // signals
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} sscr_row_t;
    logic clk, reset_n, reg_wr, reg_rd, step_enable, nvm_done, irq, fclr;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, burst_addr, burst_next, nvm_delay, v;
    logic [5:0] fifo_entries, step_sample;
    logic pv_en, single_en, peak_hit, valley_hit, st_en, st_amp, st_sign, settled, ld, pg;
    sscr_axis_t step_axis, st_axis;
    int n_fail = 0, cmp_count = 0, n_clr = 0, n_ld = 0, n_pg = 0, cyc = 0, c0;
    sscr_row_t rows[7] = '{'{8'h1F, 8'hA7, 8'hA7}, '{8'h31, 8'hFF, 8'h3F},
        '{8'h34, 8'hFF, 8'h3F}, '{8'h32, 8'h9B, 8'h9B}, '{8'h41, 8'h07, 8'h07},
        '{8'h50, 8'h55, 8'h00}, '{8'h33, 8'h80, 8'h84}};
    logic [7:0] ra[5] = '{8'h1F, 8'h31, 8'h32, 8'h33, 8'h34};
    logic [7:0] rv[5] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h00};
    // ========================================
    // design and nvm partner
    sscr_regs #(.SETTLE_CYC(20)) dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .fifo_entries(fifo_entries), .fifo_frame_count_clear(fclr), .burst_addr(burst_addr),
        .burst_next_addr(burst_next), .step_enable(step_enable), .step_sample(step_sample),
        .peak_valley_match_enable(pv_en), .single_axis_step_enable(single_en),
        .step_axis(step_axis), .step_peak_hit(peak_hit), .step_valley_hit(valley_hit),
        .selftest_enable(st_en), .selftest_amp_high(st_amp),
        .selftest_sign_positive(st_sign), .selftest_axis(st_axis),
        .selftest_settled(settled), .nonvolatile_load_trigger_start(ld), .nonvolatile_program_trigger_start(pg),
        .nvm_done(nvm_done), .irq(irq));
    sscr_nvm_model nvm (.clk(clk), .reset_n(reset_n), .load_start(ld), .prog_start(pg),
        .delay(nvm_delay), .nvm_done(nvm_done));
    // ========================================
    // clock, pulse counters, timeout
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(negedge clk) begin
        n_clr += (fclr === 1'b1);
        n_ld += (ld === 1'b1);
        n_pg += (pg === 1'b1);
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            $display("timeout");
            tally_and_finish();
        end
    end
    // ========================================
    // tasks
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string name);
        logic [7:0] q;
        rd(a, q);
        chk(name, e, q);
    endtask
    task automatic chk_rst();
        foreach (ra[i]) rdc(ra[i], rv[i], "reset value");
        $display("reset value test done");
    endtask
    task automatic nvm_op(input logic [7:0] bits, input logic [7:0] stat);
        int k;
        wr(8'h33, bits);
        rdc(8'h33, bits, "nvm busy");
        wr(8'h33, 8'h02);
        k = 0;
        v = 8'h00;
        while (v[2] !== 1'b1 && k < 40) begin
            rd(8'h33, v);
            k++;
        end
        chk("nvm idle", 8'h04, v);
        rdc(8'h40, stat, "nvm status");
    endtask
    // ========================================
    // main sequence
    initial begin
        reset_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        fifo_entries = 6'h00;
        step_sample = 6'h00;
        step_enable = 1'b0;
        burst_addr = 8'h00;
        nvm_delay = 8'h0C;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        chk_rst();
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rdc(rows[i].a, rows[i].e, "table read");
        end
        $display("register table test done");
        @(posedge clk);
        burst_addr <= 8'h3F;
        tick(2);
        chk("burst unlocked", 8'h40, burst_next);
        wr(8'h33, 8'h00);
        tick(2);
        chk("burst locked", 8'h3F, burst_next);
        @(posedge clk);
        burst_addr <= 8'h10;
        tick(2);
        chk("burst step", 8'h11, burst_next);
        $display("burst test done");
        @(posedge clk);
        step_enable <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(8'h32, {1'b1, 2'b00, i[0], i[1], i[0], i[1:0]});
            tick(3);
            chk("selftest axis", (i > 1) ? 8'h02 : 8'(i), {6'h00, st_axis});
            chk("step axis", (i > 1) ? 8'h02 : 8'(i), {6'h00, step_axis});
            chk("amplitude", {7'h00, i[0]}, {7'h00, st_amp});
            chk("match enable", {7'h00, i[0]}, {7'h00, pv_en});
            chk("single axis", {7'h00, i[1]}, {7'h00, single_en});
            chk("sign", {7'h00, i[0]}, {7'h00, st_sign});
        end
        wr(8'h32, 8'h00);
        tick(3);
        chk("selftest off", 8'h00, {7'h00, st_en});
        wr(8'h32, 8'h80);
        tick(5);
        chk("settled early", 8'h00, {7'h00, settled});
        tick(30);
        chk("settled late", 8'h01, {7'h00, settled});
        $display("selftest test done");
        wr(8'h32, 8'h10);
        wr(8'h34, 8'h2A);
        for (int c = 0; c < 4; c++) begin
            wr(8'h1F, {6'h2A, c[1:0]});
            @(posedge clk);
            step_sample <= 6'h2A ^ (6'h01 << c);
            tick(3);
            chk("peak hit", 8'h01, {7'h00, peak_hit});
            chk("valley hit", 8'h01, {7'h00, valley_hit});
            @(posedge clk);
            step_sample <= 6'h2A ^ (6'h02 << c);
            tick(3);
            chk("peak miss", 8'h00, {7'h00, peak_hit});
            chk("valley miss", 8'h00, {7'h00, valley_hit});
        end
        $display("step match test done");
        wr(8'h41, 8'h00);
        rd(8'h40, v);
        c0 = n_clr;
        wr(8'h31, 8'h05);
        tick(3);
        chk("frame clear", 8'(c0 + 1), 8'(n_clr));
        wr(8'h31, 8'h05);
        tick(3);
        chk("no frame clear", 8'(c0 + 1), 8'(n_clr));
        @(posedge clk);
        fifo_entries <= 6'h05;
        tick(4);
        rdc(8'h40, 8'h00, "level equal");
        @(posedge clk);
        fifo_entries <= 6'h06;
        tick(4);
        chk("masked irq", 8'h00, {7'h00, irq});
        wr(8'h41, 8'h01);
        tick(2);
        chk("irq raised", 8'h01, {7'h00, irq});
        rdc(8'h40, 8'h01, "watermark status");
        tick(2);
        chk("irq cleared", 8'h00, {7'h00, irq});
        rdc(8'h40, 8'h00, "status cleared");
        $display("watermark test done");
        nvm_op(8'h08, 8'h02);
        chk("load pulses", 8'h01, 8'(n_ld));
        chk("prog refused", 8'h00, 8'(n_pg));
        nvm_delay <= 8'h06;
        nvm_op(8'h02, 8'h04);
        chk("prog pulses", 8'h01, 8'(n_pg));
        $display("nvm test done");
        @(posedge clk);
        reset_n <= 1'b0;
        tick(2);
        chk("irq in reset", 8'h00, {7'h00, irq});
        @(posedge clk);
        reset_n <= 1'b1;
        chk_rst();
        tally_and_finish();
    end
endmodule
`default_nettype wire

/* include/sscr_consts.svh */
// register offsets, field positions, reset values and timing counts
`ifndef SSCR_CONSTS_SVH
`define SSCR_CONSTS_SVH

`define SSCR_ADDR_PEAK 8'h1F
`define SSCR_ADDR_WTMK 8'h31
`define SSCR_ADDR_STCONF 8'h32
`define SSCR_ADDR_NVM 8'h33
`define SSCR_ADDR_VALLEY 8'h34
`define SSCR_ADDR_IRQ_STAT 8'h40
`define SSCR_ADDR_IRQ_MASK 8'h41
`define SSCR_ADDR_FIFO_DATA 8'h3F

`define SSCR_RST_PEAK 8'h00
`define SSCR_RST_WTMK 8'h00
`define SSCR_RST_STCONF 8'h00
`define SSCR_RST_NVM 8'h04
`define SSCR_RST_VALLEY 8'h00

`define SSCR_ST_EN_BIT 7
`define SSCR_ST_AMP_BIT 4
`define SSCR_ST_SINGLE_BIT 3
`define SSCR_ST_SIGN_BIT 2
`define SSCR_NVM_UNLOCK_BIT 7
`define SSCR_NONVOLATILE_LOAD_TRIGGER_BIT 3
`define SSCR_NONVOLATILE_READY_FLAG_BIT 2
`define SSCR_NONVOLATILE_PROGRAM_TRIGGER_BIT 1

`define SSCR_IRQ_WTMK_BIT 0
`define SSCR_IRQ_LOAD_BIT 1
`define SSCR_IRQ_PROG_BIT 2

`define SSCR_SETTLE_US 3000
`define SSCR_CLK_MHZ 40
`define SSCR_SETTLE_CYC (`SSCR_SETTLE_US * `SSCR_CLK_MHZ)

`endif

/* include/sscr_pkg.sv */
// types shared by the register bank
package sscr_pkg;
    typedef enum logic [1:0] {SSCR_AXIS_X, SSCR_AXIS_Y, SSCR_AXIS_Z} sscr_axis_t;
    typedef enum {SSCR_NVM_IDLE, SSCR_NVM_LOADING, SSCR_NVM_PROGRAMMING} sscr_nvm_state_t;
endpackage

/* src/sscr_regs.sv */
// self-test, step match, watermark and nvm control register bank
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "sscr_consts.svh"

// Notes on behaviour
// R01: the watermark interrupt fires when the fifo count exceeds the level, and a changing write resets the frame counter.
// R02: the host waits three milliseconds after enabling self-test before trusting sensor output.
// R03: with self-test on, the shared bit picks high force amplitude when set and low when clear.
// R04: for the step counter the shared bit enables peak and valley matching when set.
// R05: the single-axis bit puts the step counter in single-axis mode when set.
// R06: the sign bit gives positive self-test excitation when set and negative when clear.
// R07: during self-test the axis field picks x for 00, y for 01 and z for 10 or 11.
// R08: while stepping is enabled the same field picks the step detection axis the same way.
// R09: with stepping and single-axis mode both on the field picks the single processed axis.
// R10: a six-bit valley value is held and serves as the valley match reference.
// R11: a six-bit peak value is held in the upper bits and serves as the peak match reference.
// R12: the precision field selects compared bits 5..1, 5..2, 5..3 or 5..4 for codes 00 to 11.
// R13: with the unlock bit clear a burst stays on the fifo data location, with it set it advances.
// R14: setting the load bit starts an nonvolatile_load_trigger and the bit clears itself on completion.
// R15: the ready flag reads one when no nvm operation is running and zero during one.
// R16: setting the program bit starts nvm programming and the bit clears itself on completion.
// R17: the host polls ready before triggering another load or program.
module sscr_regs
    import sscr_pkg::*;
#(
    parameter int SETTLE_CYC = `SSCR_SETTLE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // fifo side
    input wire logic [5:0] fifo_entries,
    output logic fifo_frame_count_clear,
    // burst address stepping
    input wire logic [7:0] burst_addr,
    output logic [7:0] burst_next_addr,
    // step counter
    input wire logic step_enable,
    input wire logic [5:0] step_sample,
    output logic peak_valley_match_enable,
    output logic single_axis_step_enable,
    output sscr_pkg::sscr_axis_t step_axis,
    output logic step_peak_hit,
    output logic step_valley_hit,
    // self-test drive
    output logic selftest_enable,
    output logic selftest_amp_high,
    output logic selftest_sign_positive,
    output sscr_pkg::sscr_axis_t selftest_axis,
    output logic selftest_settled,
    // nvm engine
    output logic nonvolatile_load_trigger_start,
    output logic nonvolatile_program_trigger_start,
    input wire logic nvm_done,
    // interrupt
    output logic irq
);
    import sscr_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        logic [7:0] peak;
        logic [7:0] wtmk;
        logic [7:0] stconf;
        logic unlock;
        logic load;
        logic prog;
        sscr_nvm_state_t nvm_st;
        logic [2:0] stat;
        logic [2:0] mask;
        logic [7:0] valley;
        logic [7:0] rdata;
        logic frame_clr;
        logic [7:0] burst_next;
        logic pv_en;
        logic single;
        sscr_axis_t step_axis;
        logic peak_hit;
        logic valley_hit;
        logic st_en;
        logic st_amp;
        logic st_sign;
        sscr_axis_t st_axis;
        logic [31:0] settle_cnt;
        logic settled;
        logic load_go;
        logic prog_go;
        logic wtmk_above;
        logic irq;
    } sscr_state_t;

    sscr_state_t s_r;
    sscr_state_t s_nxt;

    // ==========================================================
    // helpers
    function automatic sscr_axis_t axis_decode(input logic [1:0] code);
        case (code)
            2'h0: axis_decode = SSCR_AXIS_X;
            2'h1: axis_decode = SSCR_AXIS_Y;
            default: axis_decode = SSCR_AXIS_Z;
        endcase
    endfunction

    function automatic logic [5:0] precision_mask(input logic [1:0] code);
        case (code)
            2'h0: precision_mask = 6'h3E;
            2'h1: precision_mask = 6'h3C;
            2'h2: precision_mask = 6'h38;
            default: precision_mask = 6'h30;
        endcase
    endfunction

    logic wr_peak, wr_wtmk, wr_st, wr_nvm, wr_valley, wr_mask, rd_stat;
    logic [5:0] pmask;
    logic above;
    logic [2:0] events;

    assign wr_peak = reg_wr && reg_addr == `SSCR_ADDR_PEAK;
    assign wr_wtmk = reg_wr && reg_addr == `SSCR_ADDR_WTMK;
    assign wr_st = reg_wr && reg_addr == `SSCR_ADDR_STCONF;
    assign wr_nvm = reg_wr && reg_addr == `SSCR_ADDR_NVM;
    assign wr_valley = reg_wr && reg_addr == `SSCR_ADDR_VALLEY;
    assign wr_mask = reg_wr && reg_addr == `SSCR_ADDR_IRQ_MASK;
    assign rd_stat = reg_rd && reg_addr == `SSCR_ADDR_IRQ_STAT;

    // ==========================================================
    // next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.frame_clr = 1'b0;
        s_nxt.load_go = 1'b0;
        s_nxt.prog_go = 1'b0;
        events = 3'h0;
        pmask = precision_mask(s_r.peak[1:0]);
        above = {2'h0, fifo_entries} > {2'h0, s_r.wtmk[5:0]};
        // register writes
        if (wr_peak) begin
            s_nxt.peak = reg_wdata;
        end
        if (wr_wtmk) begin
            s_nxt.wtmk = {2'h0, reg_wdata[5:0]};
            s_nxt.frame_clr = reg_wdata[5:0] != s_r.wtmk[5:0]; // [R01]
        end
        if (wr_st) begin
            s_nxt.stconf = reg_wdata;
        end
        if (wr_valley) begin
            s_nxt.valley = {2'h0, reg_wdata[5:0]};
        end
        if (wr_mask) begin
            s_nxt.mask = reg_wdata[2:0];
        end
        if (wr_nvm) begin
            s_nxt.unlock = reg_wdata[`SSCR_NVM_UNLOCK_BIT];
        end
        // nvm sequencing
        case (s_r.nvm_st)
            SSCR_NVM_IDLE: begin
                if (wr_nvm && reg_wdata[`SSCR_NONVOLATILE_LOAD_TRIGGER_BIT]) begin
                    s_nxt.load = 1'b1; // [R14]
                    s_nxt.load_go = 1'b1;
                    s_nxt.nvm_st = SSCR_NVM_LOADING;
                end else if (wr_nvm && reg_wdata[`SSCR_NONVOLATILE_PROGRAM_TRIGGER_BIT]) begin
                    s_nxt.prog = 1'b1; // [R16]
                    s_nxt.prog_go = 1'b1;
                    s_nxt.nvm_st = SSCR_NVM_PROGRAMMING;
                end
            end
            SSCR_NVM_LOADING: begin
                if (nvm_done) begin
                    s_nxt.load = 1'b0; // [R14]
                    events[`SSCR_IRQ_LOAD_BIT] = 1'b1;
                    s_nxt.nvm_st = SSCR_NVM_IDLE;
                end
            end
            SSCR_NVM_PROGRAMMING: begin
                if (nvm_done) begin
                    s_nxt.prog = 1'b0; // [R16]
                    events[`SSCR_IRQ_PROG_BIT] = 1'b1;
                    s_nxt.nvm_st = SSCR_NVM_IDLE;
                end
            end
            default: s_nxt.nvm_st = SSCR_NVM_IDLE;
        endcase
        // watermark event on rising crossing
        s_nxt.wtmk_above = above;
        events[`SSCR_IRQ_WTMK_BIT] = above && !s_r.wtmk_above; // [R01]
        // decoded controls
        s_nxt.st_en = s_r.stconf[`SSCR_ST_EN_BIT];
        s_nxt.st_amp = s_r.stconf[`SSCR_ST_EN_BIT] && s_r.stconf[`SSCR_ST_AMP_BIT]; // [R03]
        s_nxt.pv_en = step_enable && s_r.stconf[`SSCR_ST_AMP_BIT]; // [R04]
        s_nxt.single = step_enable && s_r.stconf[`SSCR_ST_SINGLE_BIT]; // [R05] [R09]
        s_nxt.st_sign = s_r.stconf[`SSCR_ST_SIGN_BIT]; // [R06]
        s_nxt.st_axis = axis_decode(s_r.stconf[1:0]); // [R07]
        s_nxt.step_axis = axis_decode(s_r.stconf[1:0]); // [R08] [R09]
        // peak and valley matching
        s_nxt.peak_hit = s_nxt.pv_en
            && ((step_sample & pmask) == (s_r.peak[7:2] & pmask)); // [R11] [R12]
        s_nxt.valley_hit = s_nxt.pv_en
            && ((step_sample & pmask) == (s_r.valley[5:0] & pmask)); // [R10] [R12]
        // burst addressing
        if (burst_addr == `SSCR_ADDR_FIFO_DATA && !s_r.unlock) begin
            s_nxt.burst_next = burst_addr; // [R13]
        end else begin
            s_nxt.burst_next = burst_addr + 8'h01; // [R13]
        end
        // self-test settle timer
        if (!s_r.stconf[`SSCR_ST_EN_BIT]) begin
            s_nxt.settle_cnt = 32'h0;
            s_nxt.settled = 1'b0;
        end else if (s_r.settle_cnt < 32'(SETTLE_CYC)) begin
            s_nxt.settle_cnt = s_r.settle_cnt + 32'h1;
        end else begin
            s_nxt.settled = 1'b1; // [R02]
        end
        // interrupt status, set wins over read clear
        s_nxt.stat = (rd_stat ? 3'h0 : s_r.stat) | events;
        s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
        // read data
        s_nxt.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `SSCR_ADDR_PEAK: s_nxt.rdata = s_r.peak;
                `SSCR_ADDR_WTMK: s_nxt.rdata = s_r.wtmk;
                `SSCR_ADDR_STCONF: s_nxt.rdata = s_r.stconf;
                `SSCR_ADDR_NVM: s_nxt.rdata = {s_r.unlock, 3'h0, s_r.load,
                    s_r.nvm_st == SSCR_NVM_IDLE, s_r.prog, 1'b0}; // [R15]
                `SSCR_ADDR_VALLEY: s_nxt.rdata = s_r.valley;
                `SSCR_ADDR_IRQ_STAT: s_nxt.rdata = {5'h0, s_r.stat};
                `SSCR_ADDR_IRQ_MASK: s_nxt.rdata = {5'h0, s_r.mask};
                default: s_nxt.rdata = 8'h00;
            endcase
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
            s_r.peak <= `SSCR_RST_PEAK;
            s_r.wtmk <= `SSCR_RST_WTMK;
            s_r.stconf <= `SSCR_RST_STCONF;
            s_r.valley <= `SSCR_RST_VALLEY;
            s_r.nvm_st <= SSCR_NVM_IDLE;
            s_r.st_axis <= SSCR_AXIS_X;
            s_r.step_axis <= SSCR_AXIS_X;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign reg_rdata = s_r.rdata;
    assign fifo_frame_count_clear = s_r.frame_clr;
    assign burst_next_addr = s_r.burst_next;
    assign peak_valley_match_enable = s_r.pv_en;
    assign single_axis_step_enable = s_r.single;
    assign step_axis = s_r.step_axis;
    assign step_peak_hit = s_r.peak_hit;
    assign step_valley_hit = s_r.valley_hit;
    assign selftest_enable = s_r.st_en;
    assign selftest_amp_high = s_r.st_amp;
    assign selftest_sign_positive = s_r.st_sign;
    assign selftest_axis = s_r.st_axis;
    assign selftest_settled = s_r.settled;
    assign nonvolatile_load_trigger_start = s_r.load_go;
    assign nonvolatile_program_trigger_start = s_r.prog_go;
    assign irq = s_r.irq;

    // ==========================================================
    // checks
    AST_WTMK_CLEAR: assert property (@(posedge clk) disable iff (!reset_n)
        wr_wtmk && reg_wdata[5:0] != s_r.wtmk[5:0] |=> fifo_frame_count_clear) // [R01]
        else $error("frame counter not cleared on watermark change");
    AST_WTMK_EVENT: assert property (@(posedge clk) disable iff (!reset_n)
        $rose({2'h0, fifo_entries} > {2'h0, s_r.wtmk[5:0]}) && !wr_wtmk
        |=> s_r.stat[`SSCR_IRQ_WTMK_BIT]) // [R01]
        else $error("watermark crossing not flagged");
    AST_AMP: assert property (@(posedge clk) disable iff (!reset_n)
        selftest_amp_high |-> selftest_enable) // [R03]
        else $error("high amplitude outside self-test");
    AST_PV: assert property (@(posedge clk) disable iff (!reset_n)
        step_enable && s_r.stconf[`SSCR_ST_AMP_BIT] && !wr_st
        |=> peak_valley_match_enable) // [R04]
        else $error("peak valley matching not enabled");
    AST_SINGLE: assert property (@(posedge clk) disable iff (!reset_n)
        single_axis_step_enable |-> $past(s_r.stconf[`SSCR_ST_SINGLE_BIT])) // [R05]
        else $error("single axis without its bit");
    AST_SIGN: assert property (@(posedge clk) disable iff (!reset_n)
        selftest_sign_positive == $past(s_r.stconf[`SSCR_ST_SIGN_BIT])) // [R06]
        else $error("self-test sign mismatch");
    AST_AXIS: assert property (@(posedge clk) disable iff (!reset_n)
        $past(s_r.stconf[1]) |-> selftest_axis == SSCR_AXIS_Z) // [R07]
        else $error("axis code 1x did not select z");
    AST_STEP_AXIS: assert property (@(posedge clk) disable iff (!reset_n)
        $past(s_r.stconf[1:0]) == 2'h1 |-> step_axis == SSCR_AXIS_Y) // [R08]
        else $error("step axis code 01 did not select y");
    AST_SINGLE_OFF: assert property (@(posedge clk) disable iff (!reset_n)
        !$past(step_enable) |-> !single_axis_step_enable) // [R05]
        else $error("single axis without step enable");
    AST_SINGLE_AXIS: assert property (@(posedge clk) disable iff (!reset_n)
        single_axis_step_enable && $past(s_r.stconf[1:0]) == 2'h0 |-> step_axis == SSCR_AXIS_X) // [R09]
        else $error("single axis code 00 did not select x");
    AST_PEAK_GATE: assert property (@(posedge clk) disable iff (!reset_n)
        step_peak_hit |-> peak_valley_match_enable) // [R11]
        else $error("peak hit while matching off");
    AST_VALLEY_GATE: assert property (@(posedge clk) disable iff (!reset_n)
        step_valley_hit |-> peak_valley_match_enable) // [R10]
        else $error("valley hit while matching off");
    AST_PEAK_COARSE: assert property (@(posedge clk) disable iff (!reset_n)
        step_enable && s_r.stconf[`SSCR_ST_AMP_BIT] && s_r.peak[1:0] == 2'h3
        && step_sample[5:4] == s_r.peak[7:6] |=> step_peak_hit) // [R12]
        else $error("coarse peak match missed");
    AST_VALLEY_COARSE: assert property (@(posedge clk) disable iff (!reset_n)
        step_enable && s_r.stconf[`SSCR_ST_AMP_BIT] && s_r.peak[1:0] == 2'h3
        && step_sample[5:4] == s_r.valley[5:4] |=> step_valley_hit) // [R12]
        else $error("coarse valley match missed");
    AST_LOAD_START: assert property (@(posedge clk) disable iff (!reset_n)
        s_r.nvm_st == SSCR_NVM_IDLE && wr_nvm && reg_wdata[`SSCR_NONVOLATILE_LOAD_TRIGGER_BIT]
        |=> nonvolatile_load_trigger_start && s_r.load) // [R14]
        else $error("load did not start");
    AST_PROG_CLR: assert property (@(posedge clk) disable iff (!reset_n)
        s_r.nvm_st == SSCR_NVM_PROGRAMMING && nvm_done
        |=> !s_r.prog && s_r.stat[`SSCR_IRQ_PROG_BIT]) // [R16]
        else $error("program bit not cleared on done");
    AST_LOAD_CLR: assert property (@(posedge clk) disable iff (!reset_n)
        s_r.nvm_st == SSCR_NVM_LOADING && nvm_done
        |=> !s_r.load && s_r.stat[`SSCR_IRQ_LOAD_BIT]) // [R14]
        else $error("load bit not cleared on done");
    AST_PROG_START: assert property (@(posedge clk) disable iff (!reset_n)
        s_r.nvm_st == SSCR_NVM_IDLE && wr_nvm && reg_wdata[`SSCR_NONVOLATILE_PROGRAM_TRIGGER_BIT]
        && !reg_wdata[`SSCR_NONVOLATILE_LOAD_TRIGGER_BIT] |=> nonvolatile_program_trigger_start && s_r.prog) // [R16]
        else $error("program did not start");
    AST_READY: assert property (@(posedge clk) disable iff (!reset_n)
        reg_rd && reg_addr == `SSCR_ADDR_NVM
        |=> reg_rdata[`SSCR_NONVOLATILE_READY_FLAG_BIT] == !($past(s_r.load) || $past(s_r.prog))) // [R15]
        else $error("ready flag wrong");
    AST_BURST: assert property (@(posedge clk) disable iff (!reset_n)
        burst_addr == `SSCR_ADDR_FIFO_DATA && !s_r.unlock |=> burst_next_addr == 8'h3F) // [R13]
        else $error("burst address not held");
endmodule
`default_nettype wire
